// ==== src/hwmon_fan_cfg_regs.sv ====
`timescale 1ns/10ps
`default_nettype none

module hwmon_fan_cfg_regs
    import hwmon_fan_cfg_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'h3A  // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Monitor inputs
    input wire logic proc_temp_input_i,
    input wire logic [7:0] proc_temp_i,
    input wire logic [7:0] sys_temp_i,
    input wire logic temp_valid_i,
    input wire logic monitor_cycle_done_i,
    input wire logic [1:0] proc_tach_div_low_i,
    input wire logic [1:0] sys_tach_div_low_i,
    // Sensing and tachometer settings
    output logic [7:0] proc_tach_divisor_o,
    output logic [7:0] sys_tach_divisor_o,
    output logic proc_temp_diode_o,
    output logic sys_temp_diode_o,
    output logic proc_temp_current_sense_o,
    output logic sys_temp_current_sense_o,
    output logic battery_monitor_enable_o,
    output logic battery_update_o,
    // Fan drives
    output logic [7:0] proc_fan_drive_o,
    output logic [7:0] sys_fan_drive_o
);

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    // Only the top divisor bit is stored here; the low two bits arrive on pins
    function automatic logic [7:0] divisor(input logic top, input logic [1:0] low);
        logic [2:0] code;
        code = {top, low};
        divisor = 8'h01 << code;
    endfunction : divisor

    // One control step of a fan output; temp is that fan's monitored temperature
    function automatic logic [7:0] next_drive(input fan_cfg_t cfg, input logic [7:0] cur,
                                              input logic [7:0] temp);
        logic [8:0] up;
        next_drive = cur;
        up = {1'b0, cur} + {1'b0, cfg.step};
        case (cfg.mode)
            FAN_MANUAL: begin
                next_drive = cfg.manual;
            end
            FAN_TARGET_TEMP, FAN_AUTO_SPEED: begin
                if (temp > cfg.target) begin
                    if (up > {1'b0, cfg.max_out}) begin
                        next_drive = cfg.max_out;
                    end else begin
                        next_drive = up[7:0];
                    end
                end else if (temp < cfg.target) begin
                    if (cur > cfg.step) begin
                        next_drive = cur - cfg.step;
                    end else begin
                        next_drive = 8'h00;
                    end
                end
                if (cur > cfg.max_out) begin
                    next_drive = cfg.max_out;
                end
                if (cfg.mode == FAN_TARGET_TEMP && cfg.crit_en && temp > cfg.crit_temp) begin
                    next_drive = FULL_DRIVE;
                end
            end
            default: begin
                next_drive = cur;
            end
        endcase
    endfunction : next_drive

    // -----------------------------------------------------------------
    // Register bus
    // -----------------------------------------------------------------
    logic [7:0] bank_q;
    logic [7:0] batt_ctrl_q;
    logic [7:0] crit_en_q;
    logic [7:0] proc_max_q;
    logic [7:0] proc_step_q;
    logic [7:0] sys_crit_q;
    logic [7:0] proc_crit_q;
    logic [7:0] fan_mode_q;
    logic [7:0] proc_target_q;
    logic [7:0] sys_target_q;
    logic [7:0] proc_manual_q;
    logic [7:0] sys_manual_q;
    logic [7:0] rd_d;
    logic [7:0] idx;
    logic req;
    logic wr;
    logic banked;
    logic bank_hit;

    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // A write lands on the edge that raises ack; the master still holds the request
    // then, so software cannot tell it from a write on the ack edge
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign banked = (idx >= IDX_BANKED_LO) && (idx <= IDX_BANKED_HI);
    // The bank field itself is never gated, so software can always return to bank 0
    // Banked window only reaches bank 0 content; other banks read zero
    assign bank_hit = !banked || (bank_q[2:0] == 3'h0);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_comb begin
        rd_d = 8'h00;
        if (idx == IDX_BANK_CTRL) begin
            rd_d = bank_q;
        end else if (!bank_hit) begin
            rd_d = 8'h00;
        end else if (idx == IDX_PART_ID) begin
            rd_d = PART_ID;
        end else if (idx == IDX_BATT_SENSOR_CTRL) begin
            rd_d = batt_ctrl_q;
        end else if (idx == IDX_CRIT_TEMP_EN) begin
            rd_d = crit_en_q;
        end else if (idx == IDX_PROC_FAN_MAX) begin
            rd_d = proc_max_q;
        end else if (idx == IDX_PROC_FAN_STEP) begin
            rd_d = proc_step_q;
        end else if (idx == IDX_SYS_FAN_CRIT) begin
            rd_d = sys_crit_q;
        end else if (idx == IDX_PROC_FAN_CRIT) begin
            rd_d = proc_crit_q;
        end else if (idx == IDX_FAN_MODE) begin
            rd_d = fan_mode_q;
        end else if (idx == IDX_PROC_TARGET) begin
            rd_d = proc_target_q;
        end else if (idx == IDX_SYS_TARGET) begin
            rd_d = sys_target_q;
        end else if (idx == IDX_PROC_MANUAL) begin
            rd_d = proc_manual_q;
        end else if (idx == IDX_SYS_MANUAL) begin
            rd_d = sys_manual_q;
        end else if (idx == IDX_PROC_DRIVE) begin
            rd_d = proc_fan_drive_o;
        end else if (idx == IDX_SYS_DRIVE) begin
            rd_d = sys_fan_drive_o;
        end
    end

    // Read data is held between reads, so a master may pick it up after ack
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= {24'h00_0000, rd_d};
        end
    end

    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    // Part identifier has no storage, so writes to it fall through here
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bank_q <= 8'h00;
            batt_ctrl_q <= RST_BATT_SENSOR_CTRL;
            crit_en_q <= RST_CRIT_TEMP_EN;
            proc_max_q <= RST_PROC_FAN_MAX;
            proc_step_q <= RST_PROC_FAN_STEP;
            sys_crit_q <= RST_CRIT_TEMP;
            proc_crit_q <= RST_CRIT_TEMP;
            fan_mode_q <= 8'h00;
            proc_target_q <= RST_TARGET;
            sys_target_q <= RST_TARGET;
            proc_manual_q <= RST_MANUAL;
            sys_manual_q <= RST_MANUAL;
        end else if (wr) begin
            if (idx == IDX_BANK_CTRL) begin
                bank_q <= wb_dat_i[7:0] & MASK_BANK_CTRL;
            end else if (!bank_hit) begin
                bank_q <= bank_q;
            end else if (idx == IDX_BATT_SENSOR_CTRL) begin
                batt_ctrl_q <= wb_dat_i[7:0] & MASK_BATT_SENSOR_CTRL;
            end else if (idx == IDX_CRIT_TEMP_EN) begin
                crit_en_q <= wb_dat_i[7:0] & MASK_CRIT_TEMP_EN;
            end else if (idx == IDX_PROC_FAN_MAX) begin
                proc_max_q <= wb_dat_i[7:0];
            end else if (idx == IDX_PROC_FAN_STEP) begin
                proc_step_q <= wb_dat_i[7:0];
            end else if (idx == IDX_SYS_FAN_CRIT) begin
                sys_crit_q <= wb_dat_i[7:0];
            end else if (idx == IDX_PROC_FAN_CRIT) begin
                proc_crit_q <= wb_dat_i[7:0];
            end else if (idx == IDX_FAN_MODE) begin
                fan_mode_q <= wb_dat_i[7:0] & MASK_FAN_MODE;
            end else if (idx == IDX_PROC_TARGET) begin
                proc_target_q <= wb_dat_i[7:0];
            end else if (idx == IDX_SYS_TARGET) begin
                sys_target_q <= wb_dat_i[7:0];
            end else if (idx == IDX_PROC_MANUAL) begin
                proc_manual_q <= wb_dat_i[7:0];
            end else if (idx == IDX_SYS_MANUAL) begin
                sys_manual_q <= wb_dat_i[7:0];
            end
        end
    end

    // -----------------------------------------------------------------
    // Sensing and tachometer outputs
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            proc_tach_divisor_o <= 8'h01;
            sys_tach_divisor_o <= 8'h01;
            proc_temp_diode_o <= 1'b0;
            sys_temp_diode_o <= 1'b0;
            proc_temp_current_sense_o <= 1'b0;
            sys_temp_current_sense_o <= 1'b0;
        end else begin
            proc_tach_divisor_o <= divisor(batt_ctrl_q[BIT_PROC_DIV_TOP],
                                           proc_tach_div_low_i);
            sys_tach_divisor_o <= divisor(batt_ctrl_q[BIT_SYS_DIV_TOP],
                                          sys_tach_div_low_i);
            proc_temp_diode_o <= batt_ctrl_q[BIT_PROC_DIODE];
            sys_temp_diode_o <= batt_ctrl_q[BIT_SYS_DIODE];
            // Current mode overrides the type select; software sets type to diode too
            proc_temp_current_sense_o <= crit_en_q[BIT_PROC_CURRENT];
            sys_temp_current_sense_o <= crit_en_q[BIT_SYS_CURRENT];
        end
    end

    // -----------------------------------------------------------------
    // Battery monitor
    // -----------------------------------------------------------------
    // The cycle running when enable rises is partial, so its end is skipped
    logic batt_full_cycle_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            batt_full_cycle_q <= 1'b0;
        end else if (!batt_ctrl_q[BIT_BATT_EN]) begin
            batt_full_cycle_q <= 1'b0;
        end else if (monitor_cycle_done_i) begin
            batt_full_cycle_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            battery_monitor_enable_o <= 1'b0;
            battery_update_o <= 1'b0;
        end else begin
            battery_monitor_enable_o <= batt_ctrl_q[BIT_BATT_EN];
            battery_update_o <= batt_ctrl_q[BIT_BATT_EN] && batt_full_cycle_q
                                && monitor_cycle_done_i;
        end
    end

    // -----------------------------------------------------------------
    // Fan control
    // -----------------------------------------------------------------
    fan_cfg_t proc_cfg;
    fan_cfg_t sys_cfg;
    logic [7:0] proc_temp_sel;

    // Processor fan follows either temperature input, as the proc_temp_input_i pin picks
    assign proc_temp_sel = proc_temp_input_i ? proc_temp_i : sys_temp_i;

    always_comb begin
        proc_cfg.mode = fan_mode_t'(fan_mode_q[1:0]);
        proc_cfg.crit_en = crit_en_q[BIT_PROC_CRIT_EN];
        proc_cfg.crit_temp = proc_crit_q;
        proc_cfg.target = proc_target_q;
        proc_cfg.manual = proc_manual_q;
        proc_cfg.max_out = proc_max_q;
        proc_cfg.step = proc_step_q;
        sys_cfg.mode = fan_mode_t'(fan_mode_q[3:2]);
        sys_cfg.crit_en = crit_en_q[BIT_SYS_CRIT_EN];
        sys_cfg.crit_temp = sys_crit_q;
        sys_cfg.target = sys_target_q;
        sys_cfg.manual = sys_manual_q;
        // No ceiling or step register for the system fan: it ramps one code per sample
        sys_cfg.max_out = FULL_DRIVE;
        sys_cfg.step = SYS_FAN_STEP;
    end

    // Outputs move only on a fresh temperature sample, pacing the ramp
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            proc_fan_drive_o <= 8'h00;
        end else if (temp_valid_i) begin
            proc_fan_drive_o <= next_drive(proc_cfg, proc_fan_drive_o, proc_temp_sel);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sys_fan_drive_o <= 8'h00;
        end else if (temp_valid_i) begin
            sys_fan_drive_o <= next_drive(sys_cfg, sys_fan_drive_o, sys_temp_i);
        end
    end

endmodule : hwmon_fan_cfg_regs

`default_nettype wire

// ==== src/hwmon_fan_cfg_pkg.sv ====
package hwmon_fan_cfg_pkg;

    // -----------------------------------------------------------------
    // Register indexes (byte address = 4 * index)
    // -----------------------------------------------------------------
    localparam logic [7:0] IDX_BANK_CTRL = 8'h4E;
    localparam logic [7:0] IDX_PART_ID = 8'h58;
    localparam logic [7:0] IDX_BATT_SENSOR_CTRL = 8'h5D;
    localparam logic [7:0] IDX_CRIT_TEMP_EN = 8'h5E;
    localparam logic [7:0] IDX_PROC_FAN_MAX = 8'h67;
    localparam logic [7:0] IDX_PROC_FAN_STEP = 8'h68;
    localparam logic [7:0] IDX_SYS_FAN_CRIT = 8'h6B;
    localparam logic [7:0] IDX_PROC_FAN_CRIT = 8'h6C;
    localparam logic [7:0] IDX_FAN_MODE = 8'h70;
    localparam logic [7:0] IDX_PROC_TARGET = 8'h71;
    localparam logic [7:0] IDX_SYS_TARGET = 8'h72;
    localparam logic [7:0] IDX_PROC_MANUAL = 8'h73;
    localparam logic [7:0] IDX_SYS_MANUAL = 8'h74;
    localparam logic [7:0] IDX_PROC_DRIVE = 8'h75;
    localparam logic [7:0] IDX_SYS_DRIVE = 8'h76;
    localparam logic [7:0] IDX_BANKED_LO = 8'h50;
    localparam logic [7:0] IDX_BANKED_HI = 8'h5F;

    // -----------------------------------------------------------------
    // Field positions and writable masks
    // -----------------------------------------------------------------
    localparam int BIT_PROC_DIV_TOP = 6;
    localparam int BIT_SYS_DIV_TOP = 5;
    localparam int BIT_PROC_DIODE = 2;
    localparam int BIT_SYS_DIODE = 1;
    localparam int BIT_BATT_EN = 0;
    localparam int BIT_PROC_CRIT_EN = 5;
    localparam int BIT_SYS_CRIT_EN = 4;
    localparam int BIT_PROC_CURRENT = 2;
    localparam int BIT_SYS_CURRENT = 1;
    localparam logic [7:0] MASK_BATT_SENSOR_CTRL = 8'h67;
    localparam logic [7:0] MASK_CRIT_TEMP_EN = 8'h36;
    localparam logic [7:0] MASK_BANK_CTRL = 8'h07;
    localparam logic [7:0] MASK_FAN_MODE = 8'h0F;

    // -----------------------------------------------------------------
    // Reset values and fixed fan constants
    // -----------------------------------------------------------------
    localparam logic [7:0] RST_BATT_SENSOR_CTRL = 8'h04;
    localparam logic [7:0] RST_CRIT_TEMP_EN = 8'h04;
    localparam logic [7:0] RST_PROC_FAN_MAX = 8'hFF;
    localparam logic [7:0] RST_PROC_FAN_STEP = 8'h01;
    localparam logic [7:0] RST_CRIT_TEMP = 8'hFF;
    localparam logic [7:0] RST_TARGET = 8'h00;
    localparam logic [7:0] RST_MANUAL = 8'h00;
    localparam logic [7:0] FULL_DRIVE = 8'hFF;
    localparam logic [7:0] SYS_FAN_STEP = 8'h01;

    typedef enum logic [1:0] {
        FAN_MANUAL,
        FAN_TARGET_TEMP,
        FAN_AUTO_SPEED,
        FAN_MODE_SPARE
    } fan_mode_t;

    // Settings that steer one fan output
    typedef struct packed {
        fan_mode_t mode;
        logic crit_en;
        logic [7:0] crit_temp;
        logic [7:0] target;
        logic [7:0] manual;
        logic [7:0] max_out;
        logic [7:0] step;
    } fan_cfg_t;

endpackage : hwmon_fan_cfg_pkg

// ==== tb/hwmon_fan_cfg_regs_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module hwmon_fan_cfg_checker (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // Monitor strobes
    input wire logic temp_valid_i,
    input wire logic monitor_cycle_done_i,
    // Settings and drives
    input wire logic [7:0] proc_tach_divisor_o,
    input wire logic [7:0] sys_tach_divisor_o,
    input wire logic proc_temp_diode_o,
    input wire logic sys_temp_diode_o,
    input wire logic proc_temp_current_sense_o,
    input wire logic sys_temp_current_sense_o,
    input wire logic battery_monitor_enable_o,
    input wire logic battery_update_o,
    input wire logic [7:0] proc_fan_drive_o,
    input wire logic [7:0] sys_fan_drive_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in one cycle");
    a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");
    a_proc_div_onehot: assert property ($onehot(proc_tach_divisor_o))
        else $error("processor divisor not a power of two");
    a_sys_div_onehot: assert property ($onehot(sys_tach_divisor_o))
        else $error("system divisor not a power of two");
    a_batt_after_done: assert property ($rose(battery_update_o) |->
        $past(monitor_cycle_done_i) || $past(monitor_cycle_done_i, 2))
        else $error("battery update without a finished monitor cycle");
    a_batt_needs_en: assert property (battery_update_o |->
        battery_monitor_enable_o || $past(battery_monitor_enable_o))
        else $error("battery update while monitoring disabled");
    a_proc_drive_hold: assert property (!temp_valid_i |=> $stable(proc_fan_drive_o))
        else $error("processor drive moved without a control step");
    a_sys_drive_hold: assert property (!temp_valid_i |=> $stable(sys_fan_drive_o))
        else $error("system drive moved without a control step");
    a_reset_config: assert property ($rose(rst_n_i) |=>
        proc_temp_diode_o && !sys_temp_diode_o && proc_temp_current_sense_o
        && !sys_temp_current_sense_o && !battery_monitor_enable_o)
        else $error("sensing settings wrong after reset");

    c_bus_ack: cover property (wb_cyc_i && wb_stb_i && wb_ack_o);
    c_batt_update: cover property (battery_update_o);
    c_full_drive: cover property (proc_fan_drive_o == 8'hFF && sys_fan_drive_o == 8'hFF);
endmodule : hwmon_fan_cfg_checker

bind hwmon_fan_cfg_regs hwmon_fan_cfg_checker i_chk (.clk_sys_i, .rst_n_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .temp_valid_i, .monitor_cycle_done_i, .proc_tach_divisor_o,
    .sys_tach_divisor_o, .proc_temp_diode_o, .sys_temp_diode_o, .proc_temp_current_sense_o,
    .sys_temp_current_sense_o, .battery_monitor_enable_o, .battery_update_o,
    .proc_fan_drive_o, .sys_fan_drive_o);
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import hwmon_fan_cfg_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h5B;  // Arbitrary value
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [3:0] sel_v = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o;
    logic proc_temp_input_i = 1'b1, temp_valid_i = 1'b0, monitor_cycle_done_i = 1'b0;
    logic [7:0] proc_temp_i = 8'h00, sys_temp_i = 8'h00;
    logic [1:0] proc_tach_div_low_i = 2'h0, sys_tach_div_low_i = 2'h0;
    logic [7:0] proc_tach_divisor_o, sys_tach_divisor_o, proc_fan_drive_o, sys_fan_drive_o;
    logic proc_temp_diode_o, sys_temp_diode_o, battery_monitor_enable_o, battery_update_o;
    logic proc_temp_current_sense_o, sys_temp_current_sense_o;
    logic [7:0] rdv, v;
    logic seen;
    int miscompares = 0, comparisons = 0, seed = 77, e_p, stp;

    always #5 clk_sys_i = ~clk_sys_i;

    hwmon_fan_cfg_regs #(.PART_ID(ID_VAL)) i_dut (.clk_sys_i, .rst_n_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .proc_temp_input_i,
        .proc_temp_i, .sys_temp_i, .temp_valid_i, .monitor_cycle_done_i, .proc_tach_div_low_i,
        .sys_tach_div_low_i, .proc_tach_divisor_o, .sys_tach_divisor_o, .proc_temp_diode_o,
        .sys_temp_diode_o, .proc_temp_current_sense_o, .sys_temp_current_sense_o,
        .battery_monitor_enable_o, .battery_update_o, .proc_fan_drive_o, .sys_fan_drive_o);

    // ---------------------------------------------------------------
    // Bus, compare and closing tasks
    // ---------------------------------------------------------------
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_flag(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk_flag

    task automatic chk_drive(input int ep, input int es);
        chk8(proc_fan_drive_o, ep[7:0]);
        chk8(sys_fan_drive_o, es[7:0]);
    endtask : chk_drive

    task automatic tally_and_finish;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Holds the request until ack is sampled, so it is never taken twice
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, d};
        wb_sel_i <= sel_v;
        do begin
            @(posedge clk_sys_i);
        end while (wb_ack_o !== 1'b1);
        rdv = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        chk8(rdv, exp);
    endtask : rd

    task automatic fstep(input logic [7:0] tp, input logic [7:0] ts, input int ep, input int es);
        @(posedge clk_sys_i);
        proc_temp_i <= tp;
        sys_temp_i <= ts;
        temp_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        temp_valid_i <= 1'b0;
        #1;
        chk_drive(ep, es);
    endtask : fstep

    task automatic done_pulse(input logic exp);
        @(posedge clk_sys_i);
        monitor_cycle_done_i <= 1'b1;
        @(posedge clk_sys_i);
        monitor_cycle_done_i <= 1'b0;
        seen = 1'b0;
        repeat (3) begin
            #1 seen = seen | battery_update_o;
            @(posedge clk_sys_i);
        end
        chk_flag(seen, exp);
    endtask : done_pulse

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd(8'h5D, 8'h04);
        rd(8'h5E, 8'h04);
        rd(8'h67, 8'hFF);
        rd(8'h68, 8'h01);
        rd(8'h6B, 8'hFF);
        rd(8'h6C, 8'hFF);
        rd(8'h58, ID_VAL);
        wr(8'h58, ~ID_VAL);
        rd(8'h58, ID_VAL);
        wr(8'h60, 8'hAA);
        rd(8'h60, 8'h00);
        wr(8'h4E, 8'h02);
        rd(8'h58, 8'h00);
        wr(8'h5D, 8'hFF);
        wr(8'h4E, 8'h00);
        rd(8'h5D, 8'h04);
        repeat (4) begin
            v = 8'($random(seed));
            proc_tach_div_low_i <= 2'($random(seed));
            sys_tach_div_low_i <= 2'($random(seed));
            wr(8'h5D, v);
            rd(8'h5D, v & 8'h67);
            chk8(proc_tach_divisor_o, 8'h01 << {v[6], proc_tach_div_low_i});
            chk8(sys_tach_divisor_o, 8'h01 << {v[5], sys_tach_div_low_i});
            chk8({6'h00, proc_temp_diode_o, sys_temp_diode_o}, {6'h00, v[2:1]});
            chk_flag(battery_monitor_enable_o, v[0]);
            v = 8'($random(seed));
            wr(8'h5E, v);
            rd(8'h5E, v & 8'h36);
            chk8({6'h00, proc_temp_current_sense_o, sys_temp_current_sense_o}, {6'h00, v[2:1]});
        end
        wr(8'h5D, 8'h04);
        done_pulse(1'b0);
        wr(8'h5D, 8'h05);
        done_pulse(1'b0);
        done_pulse(1'b1);
        stp = ($random(seed) & 7) + 1;
        // Ceiling kept nonzero and above the stop value
        wr(8'h67, 8'h10);
        wr(8'h68, 8'(stp));
        wr(8'h71, 8'h40);
        wr(8'h72, 8'h40);
        wr(8'h70, 8'h02);
        e_p = 0;
        repeat (4) begin
            e_p = (e_p + stp > 16) ? 16 : e_p + stp;
            fstep(8'h48, 8'h48, e_p, 0);
        end
        e_p = e_p - stp;
        fstep(8'h30, 8'h30, e_p, 0);
        wr(8'h70, 8'h05);
        wr(8'h6C, 8'h50);
        wr(8'h6B, 8'h50);
        wr(8'h5E, 8'h34);
        e_p = (e_p + stp > 16) ? 16 : e_p + stp;
        fstep(8'h50, 8'h50, e_p, 1);
        fstep(8'h51, 8'h51, 255, 255);
        fstep(8'h51, 8'h51, 255, 255);
        wr(8'h5E, 8'h04);
        fstep(8'h51, 8'h51, 16, 255);
        wr(8'h5E, 8'h14);
        fstep(8'h51, 8'h51, 16, 255);
        // Processor fan follows the system input and steps down on both fans
        proc_temp_input_i <= 1'b0;
        fstep(8'h51, 8'h30, 16 - stp, 254);
        proc_temp_input_i <= 1'b1;
        rd(8'h75, 8'(16 - stp));
        rd(8'h76, 8'hFE);
        // Processor in hold mode, system fan in manual mode
        wr(8'h74, 8'h33);
        wr(8'h70, 8'h03);
        fstep(8'h70, 8'h70, 16 - stp, 8'h33);
        // A write without its low byte lane enabled is dropped
        sel_v = 4'hE;
        wr(8'h6B, 8'h11);
        sel_v = 4'hF;
        rd(8'h6B, 8'h50);
        tally_and_finish();
    end

    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
